// ### current_input_line_fault_scaling.sv
/*
  One analog current-input channel: line fault supervision against
  lead-breakage and short-circuit thresholds, parameter checking, and
  linear scaling of the loop current onto a float engineering scale.
  Assumes digitised current samples in microamps, synchronous to the
  clock, and a configuration port written by the module controller.
*/
`timescale 1ns/1ps

module current_input_line_fault_scaling
  import cur_fault_pkg::*;
(
  input wire logic i_ref_clk, // 250 MHz clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_cfg_wr, // Configuration write strobe
  input wire cfg_t i_cfg, // Configuration word
  input wire logic i_sample_valid, // New current sample
  input wire cur_t i_loop_current, // Loop current, microamps
  output logic o_sample_ready, // Scaler can take a sample
  output cfg_t o_cfg, // Configuration in force
  output logic o_param_error, // Parameter set inconsistent
  output logic o_diag_alarm, // Acyclic alarm event pulse
  output logic o_diag_fault, // Line fault state for alarm
  output cyclic_t o_cyclic, // Cyclic input data
  output logic o_value_valid // New scaled value pulse
);

  cfg_t cfg, next_cfg;
  logic lead_broken_flag, next_lead_broken_flag;
  logic shorted_loop_flag, next_shorted_loop_flag;
  logic line_fault;
  logic alarm, next_alarm;
  logic param_error, next_param_error;
  scale_state_t state, next_state;
  cur_t cur, next_cur;
  logic [31:0] frac, next_frac;
  logic signed [31:0] scaled_fix, next_scaled_fix;
  logic [31:0] value, next_value;
  logic value_seen, next_value_seen;
  logic value_valid, next_value_valid;
  logic div_start;
  logic div_done;
  logic [31:0] div_quotient;
  logic signed [31:0] dividend;
  cur_t span_cur;

  // ************************************************************
  // Float conversion helpers (Q16.16 fixed point internally)
  // ************************************************************
  function automatic logic signed [31:0] f2q(input logic [31:0] f);
    logic [7:0] e;
    logic [31:0] mag;
    e = f[30:23];
    mag = '0;
    if (e > 8'h8d)
      mag = 32'h7fffffff;
    else if (e >= 8'h86)
      mag = {8'h00, 1'b1, f[22:0]} << (e - 8'h86);
    else if (e > 8'h6e)
      mag = {8'h00, 1'b1, f[22:0]} >> (8'h86 - e);
    return f[31] ? -mag : mag;
  endfunction

  function automatic logic [31:0] q2f(input logic signed [31:0] q);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0] pos;
    mag = q[31] ? -q : q;
    pos = '0;
    for (int i = 0; i < 32; i++)
    begin
      if (mag[i])
        pos = 5'(i);
    end
    norm = mag << (5'h1f - pos);
    if (mag == '0)
      return '0;
    return {q[31], {3'b000, pos} + 8'h6f, norm[30:8]};
  endfunction

  // ************************************************************
  // Configuration and parameter check
  // ************************************************************
  always_comb
  begin
    next_cfg = i_cfg_wr ? i_cfg : cfg;
    next_param_error = 1'b0;
    if (cfg.lead_lim >= cfg.short_lim)
      next_param_error = 1'b1;
    if (cfg.zero_pt == '0 || cfg.zero_pt >= cfg.full_pt)
      next_param_error = 1'b1;
    if (cfg.lead_lim > CUR_MAX_UA || cfg.short_lim > CUR_MAX_UA)
      next_param_error = 1'b1;
    if (cfg.zero_pt > CUR_MAX_UA || cfg.full_pt > CUR_MAX_UA)
      next_param_error = 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cfg <= CFG_DEFAULT;
      param_error <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      param_error <= next_param_error;
    end
  end

  // ************************************************************
  // Line fault supervision
  // ************************************************************
  assign line_fault = lead_broken_flag | shorted_loop_flag;

  always_comb
  begin
    next_lead_broken_flag = lead_broken_flag;
    next_shorted_loop_flag = shorted_loop_flag;
    if (i_sample_valid)
    begin
      next_lead_broken_flag = i_loop_current < cfg.lead_lim;
      next_shorted_loop_flag = i_loop_current > cfg.short_lim;
    end
    next_lead_broken_flag = next_lead_broken_flag & cfg.sup_en;
    next_shorted_loop_flag = next_shorted_loop_flag & cfg.sup_en;
    next_alarm = cfg.sup_en
      && ((next_lead_broken_flag | next_shorted_loop_flag) != line_fault);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      lead_broken_flag <= 1'b0;
      shorted_loop_flag <= 1'b0;
      alarm <= 1'b0;
    end
    else
    begin
      lead_broken_flag <= next_lead_broken_flag;
      shorted_loop_flag <= next_shorted_loop_flag;
      alarm <= next_alarm;
    end
  end

  // ************************************************************
  // Scaling sequencer
  // ************************************************************
  assign span_cur = cfg.full_pt - cfg.zero_pt;
  assign dividend = {1'b0, next_cur, 16'h0000} - {1'b0, cfg.zero_pt, 16'h0000};
  assign div_start = (state == ST_IDLE) && i_sample_valid && !param_error;

  loop_ratio_divider #(
    .DIVIDEND_W(32),
    .DIVISOR_W(CUR_W)
  ) u_ratio (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(div_start),
    .i_dividend(dividend),
    .i_divisor(span_cur),
    .o_busy(),
    .o_done(div_done),
    .o_quotient(div_quotient)
  );

  always_comb
  begin
    logic signed [31:0] lower_q;
    logic signed [31:0] span_q;
    logic signed [63:0] prod;
    lower_q = f2q(cfg.lower_scale);
    span_q = 32'(f2q(cfg.upper_scale) - lower_q);
    prod = $signed(frac) * span_q;
    next_state = state;
    next_cur = cur;
    next_frac = frac;
    next_scaled_fix = scaled_fix;
    next_value = value;
    next_value_seen = value_seen;
    next_value_valid = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (div_start)
        begin
          next_cur = i_loop_current;
          next_state = ST_DIVIDE;
        end
      end
      ST_DIVIDE:
      begin
        if (div_done)
        begin
          next_frac = div_quotient;
          next_state = ST_SCALE;
        end
      end
      ST_SCALE:
      begin
        next_scaled_fix = 32'(lower_q + prod[47:16]);
        next_state = ST_PACK;
      end
      ST_PACK:
      begin
        next_value = q2f(scaled_fix);
        next_value_seen = 1'b1;
        next_value_valid = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      cur <= '0;
      frac <= '0;
      scaled_fix <= '0;
      value <= '0;
      value_seen <= 1'b0;
      value_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      frac <= next_frac;
      scaled_fix <= next_scaled_fix;
      value <= next_value;
      value_seen <= next_value_seen;
      value_valid <= next_value_valid;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_sample_ready = (state == ST_IDLE);
  assign o_cfg = cfg;
  assign o_param_error = param_error;
  assign o_diag_alarm = alarm;
  assign o_diag_fault = line_fault;
  assign o_value_valid = value_valid;

  always_comb
  begin
    o_cyclic.value = value;
    o_cyclic.status = 8'h00;
    o_cyclic.status[ST_VALUE_BIT] = value_seen;
    o_cyclic.status[ST_FAULT_BIT] = line_fault | param_error;
    o_cyclic.status[ST_LINE_BIT] = line_fault;
    o_cyclic.status[ST_LEAD_BIT] = lead_broken_flag;
    o_cyclic.status[ST_SHORT_BIT] = shorted_loop_flag;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  property p_sup_off;
    !cfg.sup_en |=> !lead_broken_flag && !shorted_loop_flag;
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("fault while off");
  property p_cyclic_bits;
    line_fault |-> o_cyclic.status[ST_LINE_BIT] && o_cyclic.status[ST_FAULT_BIT];
  endproperty
  a_cyclic_bits: assert property (p_cyclic_bits) else $error("bit missing");
  property p_alarm;
    $changed(line_fault) && $past(cfg.sup_en) |-> o_diag_alarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("no alarm");
  property p_lead;
    i_sample_valid && cfg.sup_en && i_loop_current < cfg.lead_lim
      |=> lead_broken_flag && o_cyclic.status[ST_LEAD_BIT];
  endproperty
  a_lead: assert property (p_lead) else $error("lead missed");
  property p_short;
    i_sample_valid && cfg.sup_en && i_loop_current > cfg.short_lim
      |=> shorted_loop_flag && o_cyclic.status[ST_SHORT_BIT];
  endproperty
  a_short: assert property (p_short) else $error("short missed");
  property p_order;
    cfg.lead_lim >= cfg.short_lim |=> o_param_error;
  endproperty
  a_order: assert property (p_order) else $error("order unflagged");
  property p_zero_pt;
    (cfg.zero_pt == '0 || cfg.zero_pt >= cfg.full_pt) |=> o_param_error;
  endproperty
  a_zero_pt: assert property (p_zero_pt) else $error("zero unflagged");
  property p_defaults;
    @(posedge i_ref_clk) disable iff (1'b0)
      i_rst |=> cfg == CFG_DEFAULT && !o_diag_alarm;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad defaults");
  property p_value_time;
    div_start |-> ##[34:36] o_value_valid;
  endproperty
  a_value_time: assert property (p_value_time) else $error("value late");
  property p_zero_maps;
    state == ST_SCALE && frac == '0
      |=> scaled_fix == f2q($past(cfg.lower_scale));
  endproperty
  a_zero_maps: assert property (p_zero_maps) else $error("zero not lower");

endmodule

// ### cur_fault_pkg.sv
/*
  Shared types and constants for the current-input line fault and
  scaling channel. Currents are unsigned microamps, scale limits and
  the scaled value are IEEE-754 single precision words.
*/
package cur_fault_pkg;

  localparam int CUR_W = 15;
  localparam int FRAC_BITS = 16;

  typedef logic [CUR_W-1:0] cur_t;

  // Settable range and defaults, in microamps
  localparam cur_t CUR_MAX_UA = 15'h6590;
  localparam cur_t LEAD_LIM_DEF = 15'h03e8;
  localparam cur_t SHORT_LIM_DEF = 15'h5208;
  localparam cur_t ZERO_PT_DEF = 15'h0fa0;
  localparam cur_t FULL_PT_DEF = 15'h4e20;

  // Scale limit defaults: 4.0 and 20.0
  localparam logic [31:0] LOWER_SCALE_DEF = 32'h40800000;
  localparam logic [31:0] UPPER_SCALE_DEF = 32'h41a00000;

  // Cyclic status byte bit positions
  localparam int ST_VALUE_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_LINE_BIT = 2;
  localparam int ST_LEAD_BIT = 4;
  localparam int ST_SHORT_BIT = 5;

  typedef struct packed {
    logic sup_en;
    cur_t lead_lim;
    cur_t short_lim;
    cur_t zero_pt;
    cur_t full_pt;
    logic [31:0] lower_scale;
    logic [31:0] upper_scale;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{1'b0, LEAD_LIM_DEF, SHORT_LIM_DEF,
    ZERO_PT_DEF, FULL_PT_DEF, LOWER_SCALE_DEF, UPPER_SCALE_DEF};

  typedef struct packed {
    logic [31:0] value;
    logic [7:0] status;
  } cyclic_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_SCALE, ST_PACK} scale_state_t;

endpackage

// ### loop_ratio_divider.sv
/*
  Sequential signed-by-unsigned restoring divider, one quotient bit
  per clock. Assumes a non-zero divisor; start is taken only while idle.
*/
`timescale 1ns/1ps
module loop_ratio_divider #(
  parameter int DIVIDEND_W = 32,
  parameter int DIVISOR_W = 15
) (
  input wire logic i_ref_clk, // 250 MHz clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_start, // Start pulse
  input wire logic [DIVIDEND_W-1:0] i_dividend, // Signed dividend
  input wire logic [DIVISOR_W-1:0] i_divisor, // Unsigned divisor
  output logic o_busy, // Division running
  output logic o_done, // Result valid pulse
  output logic [DIVIDEND_W-1:0] o_quotient // Signed quotient
);

  localparam int CNT_W = $clog2(DIVIDEND_W + 1);

  initial
  begin
    if (DIVIDEND_W < 2 || DIVISOR_W < 1 || DIVISOR_W >= DIVIDEND_W)
      $error("loop_ratio_divider: unsupported widths");
  end

  logic [DIVIDEND_W-1:0] quo, next_quo;
  logic [DIVISOR_W:0] rem, next_rem;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic neg, next_neg;
  logic busy, next_busy;
  logic done, next_done;
  logic [DIVIDEND_W-1:0] result, next_result;

  always_comb
  begin
    logic [DIVISOR_W:0] trial;
    logic ge;
    trial = {rem[DIVISOR_W-1:0], quo[DIVIDEND_W-1]};
    ge = (trial >= {1'b0, i_divisor});
    next_quo = quo;
    next_rem = rem;
    next_cnt = cnt;
    next_neg = neg;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    if (!busy && i_start)
    begin
      // Work on the magnitude and restore the sign at the end
      next_neg = i_dividend[DIVIDEND_W-1];
      next_quo = i_dividend[DIVIDEND_W-1] ? -i_dividend : i_dividend;
      next_rem = '0;
      next_cnt = '0;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      next_quo = {quo[DIVIDEND_W-2:0], ge};
      next_rem = ge ? trial - {1'b0, i_divisor} : trial;
      next_cnt = cnt + 1'b1;
      if (cnt == CNT_W'(DIVIDEND_W - 1))
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result = neg ? -{quo[DIVIDEND_W-2:0], ge} : {quo[DIVIDEND_W-2:0], ge};
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      quo <= '0;
      rem <= '0;
      cnt <= '0;
      neg <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end
    else
    begin
      quo <= next_quo;
      rem <= next_rem;
      cnt <= next_cnt;
      neg <= next_neg;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
    end
  end

  assign o_busy = busy;
  assign o_done = done;
  assign o_quotient = result;

endmodule

// ### loop_transmitter_model.sv
/*
  Field transmitter model: delivers loop current samples on request.
  Assumes the bench raises i_req for one cycle per sample wanted.
*/
`timescale 1ns/1ps
module loop_transmitter_model
  import cur_fault_pkg::*;
(
  input wire logic i_ref_clk, // 250 MHz clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_req, // Bench asks for a sample
  input wire cur_t i_level, // Loop current to deliver
  output logic o_sample_valid, // Sample strobe
  output cur_t o_loop_current // Loop current, microamps
);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_sample_valid <= 1'h0;
      o_loop_current <= '0;
    end
    else
    begin
      o_sample_valid <= i_req;
      // Between samples the line shows a changing pattern, never a held value
      o_loop_current <= i_req ? i_level : ~o_loop_current;
    end
  end
endmodule

// ### current_input_line_fault_scaling_bench.sv
/*
  Self-checking bench for the current-input channel: faults, alarms,
  parameter checks and scaling. Assumes the transmitter model file.
*/
`timescale 1ns/1ps
module current_input_line_fault_scaling_bench;
  import cur_fault_pkg::*;
  logic i_ref_clk, i_rst, i_cfg_wr, tx_req;
  cfg_t i_cfg, cw, o_cfg;
  cur_t tx_level, i_loop_current;
  logic i_sample_valid, o_sample_ready, o_param_error;
  logic o_diag_alarm, o_diag_fault, o_value_valid;
  cyclic_t o_cyclic;
  int fail_count, cmp_count;

  current_input_line_fault_scaling u_current_input_line_fault_scaling (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg(i_cfg),
    .i_sample_valid(i_sample_valid), .i_loop_current(i_loop_current),
    .o_sample_ready(o_sample_ready), .o_cfg(o_cfg), .o_param_error(o_param_error),
    .o_diag_alarm(o_diag_alarm), .o_diag_fault(o_diag_fault), .o_cyclic(o_cyclic),
    .o_value_valid(o_value_valid));

  loop_transmitter_model u_loop_transmitter_model (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(tx_req), .i_level(tx_level),
    .o_sample_valid(i_sample_valid), .o_loop_current(i_loop_current));

  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input logic [112:0] seen, input logic [112:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task send(input cur_t c);
    @(posedge i_ref_clk);
    tx_req <= 1'h1;
    tx_level <= c;
    @(posedge i_ref_clk);
    tx_req <= 1'h0;
    @(posedge i_ref_clk);
    #1;
  endtask

  task wr_cfg(input cfg_t c);
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'h1;
    i_cfg <= c;
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'h0;
    #1;
    check(o_diag_alarm, 1'h0, "alarm on config write");
    @(posedge i_ref_clk);
    #1;
    check(o_diag_alarm, 1'h0, "alarm on config write");
  endtask

  task fault(input cur_t c, input logic ld, input logic sh, input logic al);
    send(c);
    check(o_cyclic.status[7:1], {2'h0, sh, ld, 1'h0, ld | sh, ld | sh}, "status bits");
    check(o_diag_fault, ld | sh, "fault state");
    check(o_diag_alarm, al, "alarm pulse");
    @(posedge i_ref_clk);
    #1;
    check(o_diag_alarm, 1'h0, "alarm longer than a cycle");
  endtask

  task perr(input cfg_t c, input logic e);
    wr_cfg(c);
    check(o_cfg, c, "config readback");
    check(o_param_error, e, "parameter error");
    check(o_cyclic.status[ST_FAULT_BIT], e, "fault bit");
  endtask

  task scale(input cur_t c, input logic [31:0] exp);
    for (int i = 0; i < 100 && o_sample_ready !== 1'h1; i++)
      @(posedge i_ref_clk) #1;
    send(c);
    check(o_sample_ready, 1'h0, "ready while scaling");
    for (int i = 0; i < 60 && o_value_valid !== 1'h1; i++)
      @(posedge i_ref_clk) #1;
    check(o_value_valid, 1'h1, "no scaled value");
    check(o_sample_ready, 1'h1, "ready after value");
    check(o_cyclic.value, exp, "scaled value");
    check(o_cyclic.status[0], 1'h1, "value bit");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    check(o_cfg, CFG_DEFAULT, "defaults");
    check(o_param_error, 1'h0, "error at reset");
    check(o_sample_ready, 1'h1, "ready at reset");
    $display("test reset done");
  endtask

  task t_lead;
    fault(15'h01f4, 1'h0, 1'h0, 1'h0);
    cw = CFG_DEFAULT;
    cw.sup_en = 1'h1;
    wr_cfg(cw);
    fault(LEAD_LIM_DEF, 1'h0, 1'h0, 1'h0);
    fault(LEAD_LIM_DEF - 15'h1, 1'h1, 1'h0, 1'h1);
    fault(15'h01f4, 1'h1, 1'h0, 1'h0);
    fault(15'h1388, 1'h0, 1'h0, 1'h1);
    $display("test lead breakage done");
  endtask

  task t_short;
    fault(SHORT_LIM_DEF, 1'h0, 1'h0, 1'h0);
    fault(SHORT_LIM_DEF + 15'h1, 1'h0, 1'h1, 1'h1);
    cw.sup_en = 1'h0;
    wr_cfg(cw);
    check(o_diag_fault, 1'h0, "fault kept when off");
    check(o_cyclic.status[5:1], 5'h00, "flags kept when off");
    fault(SHORT_LIM_DEF + 15'h1, 1'h0, 1'h0, 1'h0);
    $display("test short circuit done");
  endtask

  task t_param;
    cw = CFG_DEFAULT;
    cw.lead_lim = SHORT_LIM_DEF;
    perr(cw, 1'h1);
    cw.lead_lim = SHORT_LIM_DEF - 15'h1;
    perr(cw, 1'h0);
    cw = CFG_DEFAULT;
    cw.zero_pt = '0;
    perr(cw, 1'h1);
    cw.zero_pt = FULL_PT_DEF;
    perr(cw, 1'h1);
    send(15'h2ee0);
    for (int i = 0; i < 40; i++)
      @(posedge i_ref_clk) #1 check(o_value_valid, 1'h0, "scaled with error");
    cw.zero_pt = FULL_PT_DEF - 15'h1;
    perr(cw, 1'h0);
    cw = CFG_DEFAULT;
    cw.short_lim = CUR_MAX_UA + 15'h1;
    perr(cw, 1'h1);
    $display("test parameters done");
  endtask

  task t_scale;
    perr(CFG_DEFAULT, 1'h0);
    scale(ZERO_PT_DEF, LOWER_SCALE_DEF);
    scale(FULL_PT_DEF, UPPER_SCALE_DEF);
    scale(15'h2ee0, 32'h41400000);
    cw = CFG_DEFAULT;
    cw.lower_scale = 32'h00000000;
    cw.upper_scale = 32'h42c80000;
    wr_cfg(cw);
    scale(15'h1f40, 32'h41c80000);
    $display("test scaling done");
  endtask

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial
  begin
    i_ref_clk = 1'h0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    i_rst = 1'h1;
    i_cfg_wr = 1'h0;
    i_cfg = CFG_DEFAULT;
    tx_req = 1'h0;
    tx_level = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    @(posedge i_ref_clk);
    #1;
    t_reset();
    t_lead();
    t_short();
    t_param();
    t_scale();
    complete_run();
  end

  initial
  begin
    #40000;
    fail_count++;
    complete_run();
  end
endmodule
